// ==== hdl/pbw_port_bank_wake.sv ====
// Port3 direction, bank select, port4 chip selects and wake port
// Operation
// - Port3 direction bit 0 drives data bit out; 1 makes input
// - After reset port3 high-Z, inputs read 1 until direction written
// - Bank switching forces port3 bit-7 pin to output
// - With bank switching, bit-7 pin carries address bit 16 on fetches
// - Bank switching off: address bit 15 passes, bit 7 normal I/O
// - Bank number maps core MSB to pin bits 15 and 16
// - Upper five bank register bits are plain read/write storage
// - Port4 data drives pin only if direction and select enable 0
// - Port4 direction selects input or output while select enable 0
// - Select enable 1 turns port4 pin into chip-select output
// - Reset sets all select enables; all selects sit high
// - Selects active low, released after access, set on next address
// - Eight selects decode doubling ranges from 0100H to FFFFH
// - Addresses 0000H-00FFH are internal; no select covers them
// - Wake input enable 0 ignores wake pins; 1 enables them
// - Wake register bits 6 and 5 read pin levels when enabled
// - Wake pin A polarity selects rising/true or falling/complement
// - Wake pin B polarity selects rising/true or falling/complement
// - Pin A edge enable lets a selected transition wake
// - Leave power-down on any enabled wake condition
// - Pin B edge enable lets a selected transition wake
// - Level-AND enable wakes when both adjusted levels are true
// - Wake edges are not glitch filtered
`timescale 1ns/1ps
`default_nettype none
module pbw_port_bank_wake
   import pbw_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_b,
   input  wire pbw_bus_s  bus,
   output logic [7:0]     rdata_q,
   output logic           addr15_q,
   input  wire logic [7:0] p3_data,
   input  wire logic [7:0] p3_pin_in,
   output logic [7:0]     p3_in_q,
   output pbw_pins_s      p3_q,
   input  wire logic [7:0] p4_pin_in,
   output pbw_pins_s      p4_q,
   input  wire logic [1:0] wake_pin_in,
   input  wire logic      pwr_down,
   output logic           wake_q
);
   // ==================================================
   // Functions
   // ==================================================
   // One-hot active-high select from address, none below 0100H
   function automatic logic [7:0] sel_decode(input logic [15:0] a);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         if (a[8+i] && (s == 8'h00)) begin
            s[i] = 1'b1;
         end
      end
      return s;
   endfunction

   // Returns {bit16, bit15} for a fetch with bank switching on
   function automatic logic [1:0] bank_map(input logic [1:0] bn,
                                           input logic msb);
      logic [1:0] r;
      r = 2'b00;
      if (msb) begin
         unique case (bn)
            2'b00: r = 2'b01;
            2'b01: r = 2'b10;
            2'b10: r = 2'b11;
            2'b11: r = 2'b10;
         endcase
      end
      return r;
   endfunction

   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] ofs);
      return a == ofs;
   endfunction

   // ==================================================
   // Registers
   // ==================================================
   logic [7:0] port3_dir_bits_q;
   logic [7:0] bank_q;
   logic [7:0] p4_data_q;
   logic [7:0] port4_dir_bits_q;
   logic [7:0] sel_en_q;
   logic [7:0] wake_ctl_q;
   logic       p3_written_q;

   wire wr_port3_dir_bits = bus.we && hit(bus.addr, PBW_OFS_P3_DIR);
   wire wr_bank = bus.we && hit(bus.addr, PBW_OFS_BANK);
   wire wr_p4d  = bus.we && hit(bus.addr, PBW_OFS_P4_DATA);
   wire wr_port4_dir_bits = bus.we && hit(bus.addr, PBW_OFS_P4_DIR);
   wire wr_sel  = bus.we && hit(bus.addr, PBW_OFS_SEL_EN);
   wire wr_wake = bus.we && hit(bus.addr, PBW_OFS_WAKE);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port3_dir_bits_q       <= PBW_RST_P3_DIR;
         bank_q       <= PBW_RST_BANK;
         p4_data_q    <= PBW_RST_P4_DATA;
         port4_dir_bits_q       <= PBW_RST_P4_DIR;
         sel_en_q     <= PBW_RST_SEL_EN;
         wake_ctl_q   <= PBW_RST_WAKE;
         p3_written_q <= 1'b0;
      end else begin
         if (wr_port3_dir_bits) port3_dir_bits_q <= bus.wdata;
         if (wr_bank) bank_q <= bus.wdata;
         if (wr_p4d)  p4_data_q <= bus.wdata;
         if (wr_port4_dir_bits) port4_dir_bits_q <= bus.wdata;
         if (wr_sel)  sel_en_q <= bus.wdata;
         if (wr_wake) wake_ctl_q <= bus.wdata;
         if (wr_port3_dir_bits) p3_written_q <= 1'b1;
      end
   end

   wire       bank_en  = bank_q[PBW_BANK_EN_BIT];
   wire [1:0] bank_num = {bank_q[PBW_BANK_HI_BIT],
                          bank_q[PBW_BANK_LO_BIT]};
   wire wk_en    = wake_ctl_q[PBW_WK_EN_BIT];
   wire wk_a_pol = wake_ctl_q[PBW_WK_A_POL_BIT];
   wire wk_b_pol = wake_ctl_q[PBW_WK_B_POL_BIT];
   wire wk_a_edg = wake_ctl_q[PBW_WK_A_EDG_BIT];
   wire wk_b_edg = wake_ctl_q[PBW_WK_B_EDG_BIT];
   wire wk_and   = wake_ctl_q[PBW_WK_AND_BIT];

   // ==================================================
   // Pin synchronisers
   // ==================================================
   logic [17:0] pins_s;
   pbw_sync #(.W(18)) u_sync (
      .clk     (clk),
      .rst_b   (rst_b),
      .d       ({wake_pin_in, p4_pin_in, p3_pin_in}),
      .rst_val ('0),
      .q       (pins_s)
   );
   wire [7:0] p3_s   = pins_s[7:0];
   wire [7:0] p4_s   = pins_s[15:8];
   wire [1:0] wake_s = pins_s[17:16];

   // ==================================================
   // Port3 and bank switching
   // ==================================================
   wire [1:0] bmap    = bank_map(bank_num, bus.addr[15]);
   wire       fetch_b = bank_en && bus.fetch;
   wire       a15_d   = fetch_b ? bmap[0] : bus.addr[15];
   wire       a16_d   = fetch_b ? bmap[1] : 1'b0;

   wire [7:0] p3_oe_io = p3_written_q ? ~port3_dir_bits_q : 8'h00;
   logic [7:0] p3_oe_d;
   logic [7:0] p3_out_d;
   always_comb begin
      p3_oe_d  = p3_oe_io;
      p3_out_d = p3_data;
      if (bank_en) begin
         p3_oe_d[PBW_P3_BANK_PIN]  = 1'b1;
         p3_out_d[PBW_P3_BANK_PIN] = a16_d;
      end
   end
   wire [7:0] p3_in_d = p3_written_q ? p3_s : PBW_P3_IN_IDLE;

   // ==================================================
   // Port4 and chip selects
   // ==================================================
   wire [7:0] sel_hit = sel_decode(bus.addr);
   wire [7:0] sel_n_d = bus.sel ? ~sel_hit : PBW_SEL_IDLE;
   wire [7:0] p4_out_d = (sel_en_q & sel_n_d)
                       | (~sel_en_q & p4_data_q);
   wire [7:0] p4_oe_d  = sel_en_q | ~port4_dir_bits_q;

   // ==================================================
   // Wake port
   // ==================================================
   // Disabled pins are held high internally
   wire [1:0] wk_lvl = wk_en ? wake_s : 2'b11;
   logic [1:0] wk_prev_q;
   wire wk_a_adj  = wk_lvl[1] ^ wk_a_pol;
   wire wk_b_adj  = wk_lvl[0] ^ wk_b_pol;
   wire wk_a_prev = wk_prev_q[1] ^ wk_a_pol;
   wire wk_b_prev = wk_prev_q[0] ^ wk_b_pol;
   // A single-sample change to the adjusted-true level counts, no filter
   wire wk_a_edge = wk_a_adj && !wk_a_prev;
   wire wk_b_edge = wk_b_adj && !wk_b_prev;
   wire wk_cond = (wk_a_edg && wk_a_edge)
                | (wk_b_edg && wk_b_edge)
                | (wk_and && wk_a_adj && wk_b_adj);
   wire wake_d = pwr_down && wk_en && wk_cond;

   wire [7:0] wake_rd = {wk_en, wk_lvl, wake_ctl_q[4:0]};

   // ==================================================
   // Read data
   // ==================================================
   logic [7:0] rd_d;
   always_comb begin
      rd_d = PBW_RD_UNMAPPED;
      if (hit(bus.addr, PBW_OFS_P3_DIR))  rd_d = port3_dir_bits_q;
      if (hit(bus.addr, PBW_OFS_BANK))    rd_d = bank_q;
      if (hit(bus.addr, PBW_OFS_P4_DATA)) rd_d = p4_s;
      if (hit(bus.addr, PBW_OFS_P4_DIR))  rd_d = port4_dir_bits_q;
      if (hit(bus.addr, PBW_OFS_SEL_EN))  rd_d = sel_en_q;
      if (hit(bus.addr, PBW_OFS_WAKE))    rd_d = wake_rd;
   end

   // ==================================================
   // Output flops
   // ==================================================
   logic [7:0] sel_n_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q   <= PBW_RD_UNMAPPED;
         addr15_q  <= 1'b0;
         p3_in_q   <= PBW_P3_IN_IDLE;
         p3_q      <= '0;
         p4_q.out  <= PBW_SEL_IDLE;
         p4_q.oe   <= PBW_RST_SEL_EN;
         sel_n_q   <= PBW_SEL_IDLE;
         wk_prev_q <= 2'b11;
         wake_q    <= 1'b0;
      end else begin
         if (bus.re) rdata_q <= rd_d;
         addr15_q  <= a15_d;
         p3_in_q   <= p3_in_d;
         p3_q.out  <= p3_out_d;
         p3_q.oe   <= p3_oe_d;
         p4_q.out  <= p4_out_d;
         p4_q.oe   <= p4_oe_d;
         sel_n_q   <= sel_n_d;
         wk_prev_q <= wk_lvl;
         wake_q    <= wake_d;
      end
   end

   // ==================================================
   // Assertions
   // ==================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_p3_dir_drive: assert property (
      (p3_written_q && !bank_en) |=> (p3_q.oe == ~$past(port3_dir_bits_q))
   ) else $error("port3 enable does not follow direction");

   a_p3_reset_idle: assert property (
      !p3_written_q |=> (p3_in_q == 8'hff) && (p3_q.oe[6:0] == 7'h00)
   ) else $error("port3 not idle before direction write");

   a_bank_pin_out: assert property (
      bank_en |=> p3_q.oe[7]
   ) else $error("bank pin not forced to output");

   a_bank_data_zero: assert property (
      (bank_en && !bus.fetch) |=> !p3_q.out[7]
   ) else $error("bank pin active on data access");

   a_a15_pass: assert property (
      (!bank_en || !bus.fetch) |=> addr15_q == $past(bus.addr[15])
   ) else $error("address bit 15 altered");

   a_bank_map_01: assert property (
      (bank_en && bus.fetch && bus.addr[15] && bank_num == 2'b01)
      |=> !addr15_q && p3_q.out[7]
   ) else $error("bank 01 mapping wrong");

   a_bank_map_10: assert property (
      (bank_en && bus.fetch && bus.addr[15] && bank_num == 2'b10)
      |=> addr15_q && p3_q.out[7]
   ) else $error("bank 10 mapping wrong");

   a_p4_gpio_oe: assert property (
      ##1 (p4_q.oe & ~$past(sel_en_q)) == (~$past(port4_dir_bits_q) & ~$past(sel_en_q))
   ) else $error("port4 enable ignores direction");

   a_p4_sel_pin: assert property (
      ##1 (p4_q.oe & $past(sel_en_q)) == $past(sel_en_q)
   ) else $error("select pin not driven");

   a_sel_release: assert property (
      !bus.sel |=> sel_n_q == 8'hff
   ) else $error("select held after access");

   a_sel_internal: assert property (
      (bus.sel && bus.addr[15:8] == 8'h00) |=> sel_n_q == 8'hff
   ) else $error("select in internal range");

   a_sel_top: assert property (
      (bus.sel && bus.addr[15]) |=> sel_n_q == 8'h7f
   ) else $error("top select decode wrong");

   a_wake_off: assert property (
      !wk_en |=> !wake_q
   ) else $error("wake with inputs disabled");

   a_wake_level: assert property (
      (pwr_down && wk_en && wk_and && wk_a_adj && wk_b_adj) |=> wake_q
   ) else $error("level wake missed");

   a_wake_edge_a: assert property (
      (pwr_down && wk_en && wk_a_edg && wk_a_edge) |=> wake_q
   ) else $error("pin A edge wake missed");

   a_wake_edge_b: assert property (
      (pwr_down && wk_en && wk_b_edg && wk_b_edge) |=> wake_q
   ) else $error("pin B edge wake missed");

   a_wake_none: assert property (
      (!wk_a_edg && !wk_b_edg && !wk_and) |=> !wake_q
   ) else $error("wake with no condition enabled");

   a_wake_read: assert property (
      (bus.re && wk_en && hit(bus.addr, PBW_OFS_WAKE))
      |=> rdata_q[6:5] == $past(wake_s)
   ) else $error("wake pin levels not read back");

   a_p4_read_pins: assert property (
      (bus.re && hit(bus.addr, PBW_OFS_P4_DATA)) |=> rdata_q == $past(p4_s)
   ) else $error("port4 read does not return pins");

   a_p3_in_sync: assert property (
      p3_written_q |=> p3_in_q == $past(p3_s)
   ) else $error("port3 input not from synchronised pins");

   a_bank_fetch_low: assert property (
      (bank_en && bus.fetch && !bus.addr[15]) |=> !addr15_q && !p3_q.out[7]
   ) else $error("low fetch mapping wrong");

   a_bank_map_00: assert property (
      (bank_en && bus.fetch && bus.addr[15] && bank_num == 2'b00)
      |=> addr15_q && !p3_q.out[7]
   ) else $error("bank 00 mapping wrong");

   a_sel_bottom: assert property (
      (bus.sel && bus.addr[15:8] == 8'h01) |=> sel_n_q == 8'hfe
   ) else $error("bottom select decode wrong");

   c_bank_fetch: cover property (bank_en && bus.fetch && bus.addr[15]);
   c_sel_access: cover property (bus.sel ##1 !bus.sel);
   c_wake_edge:  cover property (pwr_down && wk_a_edg && wk_a_edge);
   c_p3_write:   cover property (wr_port3_dir_bits ##1 p3_written_q);
endmodule // pbw_port_bank_wake
`default_nettype wire

// ==== hdl/pbw_sync.sv ====
// Two-stage synchroniser for pin levels entering the core clock domain
`timescale 1ns/1ps
`default_nettype none
module pbw_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;

   // Reset to constants only; rst_val is not applied anywhere
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d;
         q    <= s1_q;
      end
   end
   logic unused_rst_val;
   assign unused_rst_val = ^rst_val;
endmodule // pbw_sync
`default_nettype wire

// ==== inc/pbw_pkg.sv ====
// Constants, register map and carrier types of the port, bank and wake block
`default_nettype none
package pbw_pkg;
   // ==================================================
   // Register map (external data space byte addresses)
   // ==================================================
   localparam logic [15:0] PBW_OFS_P3_DIR  = 16'h0001;
   localparam logic [15:0] PBW_OFS_BANK    = 16'h0002;
   localparam logic [15:0] PBW_OFS_P4_DATA = 16'h0003;
   localparam logic [15:0] PBW_OFS_P4_DIR  = 16'h0004;
   localparam logic [15:0] PBW_OFS_SEL_EN  = 16'h0005;
   localparam logic [15:0] PBW_OFS_WAKE    = 16'h0006;
   localparam logic [7:0]  PBW_INT_PAGE    = 8'h00;

   // ==================================================
   // Reset values
   // ==================================================
   localparam logic [7:0] PBW_RST_P3_DIR  = 8'hff;
   localparam logic [7:0] PBW_RST_BANK    = 8'h00;
   localparam logic [7:0] PBW_RST_P4_DATA = 8'h00;
   localparam logic [7:0] PBW_RST_P4_DIR  = 8'hff;
   localparam logic [7:0] PBW_RST_SEL_EN  = 8'hff;
   localparam logic [7:0] PBW_RST_WAKE    = 8'h60;
   localparam logic [7:0] PBW_P3_IN_IDLE  = 8'hff;
   localparam logic [7:0] PBW_SEL_IDLE    = 8'hff;
   localparam logic [7:0] PBW_RD_UNMAPPED = 8'h00;

   // ==================================================
   // Field positions
   // ==================================================
   localparam int PBW_BANK_EN_BIT  = 2;
   localparam int PBW_BANK_HI_BIT  = 1;
   localparam int PBW_BANK_LO_BIT  = 0;
   localparam int PBW_P3_BANK_PIN  = 7;
   localparam int PBW_WK_EN_BIT    = 7;
   localparam int PBW_WK_A_LVL_BIT = 6;
   localparam int PBW_WK_B_LVL_BIT = 5;
   localparam int PBW_WK_A_POL_BIT = 4;
   localparam int PBW_WK_B_POL_BIT = 3;
   localparam int PBW_WK_A_EDG_BIT = 2;
   localparam int PBW_WK_B_EDG_BIT = 1;
   localparam int PBW_WK_AND_BIT   = 0;

   // ==================================================
   // Carrier types
   // ==================================================
   typedef struct packed {
      logic        sel;    // Data access in progress, address valid
      logic        we;     // One-cycle write strobe
      logic        re;     // One-cycle read strobe
      logic        fetch;  // Current address is an instruction fetch
      logic [15:0] addr;   // Core address, bit 15 is the core MSB
      logic [7:0]  wdata;
   } pbw_bus_s;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pbw_pins_s;
endpackage
`default_nettype wire

// ==== sim/pbw_far_side.sv ====
// Far-side pad model: external drivers on the two ports, pull-ups on port4 only
`timescale 1ns/1ps
`default_nettype none
module pbw_far_side
   import pbw_pkg::*;
(
   input  wire pbw_pins_s  p3_q,
   input  wire pbw_pins_s  p4_q,
   input  wire logic [7:0] p3_ext,
   input  wire logic [7:0] p4_ext_oe,
   input  wire logic [7:0] p4_ext,
   output logic      [7:0] p3_pin_in,
   output logic      [7:0] p4_pin_in
);
   // ==================================================
   // Pad resolution
   // ==================================================
   wire logic [7:0] p4_far;
   // Undriven port4 pads float up to 1
   assign p4_far    = (p4_ext_oe & p4_ext) | ~p4_ext_oe;
   assign p3_pin_in = (p3_q.oe & p3_q.out) | (~p3_q.oe & p3_ext);
   assign p4_pin_in = (p4_q.oe & p4_q.out) | (~p4_q.oe & p4_far);
endmodule // pbw_far_side
`default_nettype wire

// ==== sim/pbw_port_bank_wake_tb.sv ====
// Self-checking bench of the port, bank and wake block
`timescale 1ns/1ps
`default_nettype none
module pbw_port_bank_wake_tb
   import pbw_pkg::*;
();
   // ==================================================
   // Stimulus and wiring
   // ==================================================
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   pbw_bus_s   bus = '0;
   logic [7:0] p3_data = 8'h00;
   logic [7:0] p3_ext = 8'h3c;
   logic [7:0] p4_ext = 8'h00;
   logic [7:0] p4_ext_oe = 8'h00;
   logic [1:0] wake_pin_in = 2'h0;
   logic       pwr_down = 1'b0;
   logic [7:0] p3_pin_in, p4_pin_in, p3_in_q, rdata_q;
   logic       addr15_q, wake_q;
   pbw_pins_s  p3_q, p4_q;
   int         bad_count = 0;
   int         checks = 0;

   always #4 clk = ~clk;

   pbw_port_bank_wake pbw_port_bank_wake_i (
      .clk(clk), .rst_b(rst_b), .bus(bus), .rdata_q(rdata_q),
      .addr15_q(addr15_q), .p3_data(p3_data), .p3_pin_in(p3_pin_in),
      .p3_in_q(p3_in_q), .p3_q(p3_q), .p4_pin_in(p4_pin_in),
      .p4_q(p4_q), .wake_pin_in(wake_pin_in), .pwr_down(pwr_down),
      .wake_q(wake_q));

   pbw_far_side pbw_far_side_i (
      .p3_q(p3_q), .p4_q(p4_q), .p3_ext(p3_ext), .p4_ext_oe(p4_ext_oe),
      .p4_ext(p4_ext), .p3_pin_in(p3_pin_in), .p4_pin_in(p4_pin_in));

   // ==================================================
   // Shared tasks
   // ==================================================
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, exp, input string m);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got,
                  exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus.we = 1'b1;
      bus.addr = a;
      bus.wdata = d;
      tick(1);
      bus.we = 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e,
                     input string m);
      bus.re = 1'b1;
      bus.addr = a;
      tick(1);
      bus.re = 1'b0;
      chk8(rdata_q, e, m);
      tick(1);
   endtask

   task automatic addr_chk(input logic [15:0] a, input logic f,
                           input logic [2:0] e, input string m);
      bus.addr = a;
      bus.fetch = f;
      tick(1);
      chk8({5'h0, p3_q.out[7] & p3_q.oe[7], addr15_q, p3_q.oe[7]},
           {5'h0, e}, m);
      bus.fetch = 1'b0;
   endtask

   task automatic sel_chk(input logic [15:0] a, input logic [7:0] e);
      bus.sel = 1'b1;
      bus.addr = a;
      tick(2);
      chk8(p4_q.out, e, "select decode");
      bus.sel = 1'b0;
      tick(1);
      chk8(p4_q.out, 8'hff, "select release");
   endtask

   // ==================================================
   // Scenarios
   // ==================================================
   task automatic t_reset;
      chk8(p3_in_q, 8'hff, "p3 input idle");
      chk8(p3_q.oe, 8'h00, "p3 high-z");
      chk8(p4_q.out, 8'hff, "selects idle");
      chk8(p4_q.oe, 8'hff, "selects driven");
      rd(PBW_OFS_P3_DIR, 8'hff, "port3_dir_bits reset");
      rd(PBW_OFS_BANK, 8'h00, "bank reset");
      rd(PBW_OFS_P4_DIR, 8'hff, "port4_dir_bits reset");
      rd(PBW_OFS_SEL_EN, 8'hff, "select enable reset");
      rd(PBW_OFS_WAKE, 8'h60, "wake reset");
      rd(PBW_OFS_P4_DATA, 8'hff, "p4 pins");
      rd(16'h0007, 8'h00, "unmapped");
   endtask

   task automatic t_selects;
      for (int i = 0; i < 8; i++) begin
         sel_chk(16'h0100 << i, ~(8'h01 << i));
         sel_chk((16'h0200 << i) - 16'h1, ~(8'h01 << i));
      end
      sel_chk(16'h00ff, 8'hff);
   endtask

   task automatic t_port3;
      p3_data = 8'ha5;
      wr(PBW_OFS_P3_DIR, 8'h0f);
      tick(5);
      chk8(p3_q.oe, 8'hf0, "p3 oe");
      chk8(p3_q.out & 8'hf0, 8'ha0, "p3 out");
      chk8(p3_in_q, 8'hac, "p3 input");
   endtask

   task automatic t_bank;
      logic [1:0] map [4];
      logic [7:0] v;
      map = '{2'b01, 2'b10, 2'b11, 2'b10};
      for (int b = 0; b < 4; b++) begin
         v = 8'ha4 | 8'(b);
         wr(PBW_OFS_BANK, v);
         rd(PBW_OFS_BANK, v, "bank storage");
         addr_chk(16'h8000, 1'b1, {map[b], 1'b1}, "bank fetch");
         addr_chk(16'h1234, 1'b1, 3'b001, "low fetch");
         addr_chk(16'h8000, 1'b0, 3'b011, "data access");
      end
      wr(PBW_OFS_BANK, 8'h00);
      addr_chk(16'h8000, 1'b1, 3'b111, "bank off");
   endtask

   task automatic t_port4;
      wr(PBW_OFS_SEL_EN, 8'h0f);
      wr(PBW_OFS_P4_DIR, 8'h3c);
      wr(PBW_OFS_P4_DATA, 8'h5a);
      p4_ext_oe = 8'h30;
      p4_ext = 8'h10;
      tick(4);
      chk8(p4_q.oe, 8'hcf, "p4 oe");
      chk8(p4_q.out & 8'hcf, 8'h4f, "p4 out");
      rd(PBW_OFS_P4_DATA, 8'h5f, "p4 pins");
   endtask

   task automatic wake_case(input logic [7:0] c, input logic [1:0] p0,
                            input logic [1:0] p1, input logic e);
      int n;
      pwr_down = 1'b0;
      wake_pin_in = p0;
      wr(PBW_OFS_WAKE, c);
      tick(4);
      pwr_down = 1'b1;
      tick(2);
      chk8({7'h0, wake_q}, 8'h00, "early wake");
      wake_pin_in = p1;
      n = 0;
      if (e)
         while (wake_q !== 1'b1 && n < 12) begin
            tick(1);
            n++;
         end
      else
         tick(10);
      chk8({7'h0, wake_q}, {7'h0, e}, "wake result");
      if (e && n == 12 && wake_q !== 1'b1)
         tally_and_finish;
   endtask

   task automatic t_wake;
      logic [7:0] c [9];
      logic [1:0] p0 [9];
      logic [1:0] p1 [9];
      logic       e [9];
      c  = '{8'h84, 8'h94, 8'h82, 8'h8a, 8'h81, 8'h99, 8'h80, 8'h84,
             8'h07};
      p0 = '{2'b00, 2'b10, 2'b00, 2'b01, 2'b00, 2'b11, 2'b00, 2'b10,
             2'b00};
      p1 = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b11, 2'b00, 2'b10, 2'b00,
             2'b11};
      e  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      wake_pin_in = 2'b10;
      wr(PBW_OFS_WAKE, 8'h80);
      tick(3);
      rd(PBW_OFS_WAKE, 8'hc0, "wake pin levels");
      for (int i = 0; i < 9; i++)
         wake_case(c[i], p0[i], p1[i], e[i]);
      rd(PBW_OFS_WAKE, 8'h67, "wake disabled read");
   endtask

   task automatic t_glitch;
      int n;
      pwr_down = 1'b0;
      wake_pin_in = 2'b00;
      wr(PBW_OFS_WAKE, 8'h84);
      tick(4);
      pwr_down = 1'b1;
      wake_pin_in = 2'b10;
      tick(1);
      wake_pin_in = 2'b00;
      n = 0;
      while (wake_q !== 1'b1 && n < 6) begin
         tick(1);
         n++;
      end
      chk8({7'h0, wake_q}, 8'h01, "one-cycle glitch wake");
      pwr_down = 1'b0;
      if (wake_q !== 1'b1)
         tally_and_finish;
   endtask

   task automatic t_midreset;
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      tick(1);
      t_reset;
   endtask

   initial begin
      tick(10);
      rst_b = 1'b1;
      tick(1);
      t_reset;
      t_selects;
      t_port3;
      t_bank;
      t_port4;
      t_wake;
      t_glitch;
      t_midreset;
      tally_and_finish;
   end
endmodule // pbw_port_bank_wake_tb
`default_nettype wire
